// *** hw/keypad_panel_menu_controller.sv ***
// Purpose: Front panel keys, display, lamps and three-level menu
// Assumes: Keys active high and synchronous; core settles param_rdata
// Notes: Registers on AXI4-Lite
// How it works
// - Source lamp: keypad off, terminal on, host flash
// - Run lamp: running on, stopping flash
// - Direction lamp on forward, off reverse
// - Fault lamp follows fault condition
// - Unit lamps show kind of shown quantity
// - Program key toggles programming, backs one level
// - Confirm descends a level, stores at third
// - Up/down step group, code or value
// - Shift moves edit digit or monitor quantity
// - Run key starts drive or tuning, keypad only
// - Stop key stops, or clears stopped fault
// - Five second all-on initialisation at power-up
// - Stopped: flash value, shift steps n codes
// - Run command moves panel to running view
// - Running: shift steps r codes, confirm views
// - Fault shows flashing code, program opens log
// - Reset returns to normal only if cleared
// - Menu levels: group, code, value
// - Confirm at third saves, advances code
// - Program at third discards, keeps code
// - Multi-function key: none, forward jog, reverse jog
// - Source setting gates run key and stop command; stop key clears a fault from any source
//
// The AXI4-Lite slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module keypad_panel_menu_controller #(
  parameter int INIT_CYCLES = panel_pkg::INIT_CYCLES,
  parameter int DEBOUNCE_CYCLES = panel_pkg::DEBOUNCE_CYCLES,
  parameter int FLASH_CYCLES = panel_pkg::FLASH_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [7:0] keys_raw,
  input wire panel_pkg::drive_status_t drive_status,
  input wire panel_pkg::quantity_t monitor_kind,
  input wire logic [15:0] monitor_value,
  input wire logic [15:0] param_rdata,
  output panel_pkg::display_t display,
  output panel_pkg::lamps_t lamps,
  output panel_pkg::drive_cmd_t drive_cmd,
  output logic [5:0] monitor_sel,
  output logic [8:0] param_addr,
  output logic [15:0] param_wdata,
  output logic param_write
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [4:0] next_idx(input logic [4:0] v, input logic [4:0] max);
    return (v >= max) ? 5'h00 : v + 5'h01;
  endfunction

  function automatic logic [15:0] digit_step(input logic [1:0] d);
    return 16'h0001 << {d, 2'b00};
  endfunction

  function automatic logic [19:0] hex4(input logic [15:0] v);
    return {1'b0, v[15:12], 1'b0, v[11:8], 1'b0, v[7:4], 1'b0, v[3:0]};
  endfunction

  function automatic logic [9:0] dec2(input logic [4:0] v);
    return (v >= 5'd10) ? {5'h01, 5'(v - 5'd10)} : {5'h00, v};
  endfunction

  function automatic logic [2:0] unit_lamps(input panel_pkg::quantity_t k);
    case (k)
      panel_pkg::Q_FREQ: return panel_pkg::UNIT_HZ;
      panel_pkg::Q_CURR: return panel_pkg::UNIT_A;
      panel_pkg::Q_VOLT: return panel_pkg::UNIT_V;
      panel_pkg::Q_SPEED: return panel_pkg::UNIT_RPM;
      panel_pkg::Q_TIME: return panel_pkg::UNIT_TIME;
      panel_pkg::Q_PCT: return panel_pkg::UNIT_PCT;
      default: return 3'b000;
    endcase
  endfunction

  // ****************************************
  // Key debounce and flash timebase
  // ****************************************
  logic [31:0] db_cnt_reg;
  logic [31:0] flash_cnt_reg;
  logic [31:0] init_cnt_reg;
  logic [7:0] key_sample_reg;
  logic [7:0] key_state_reg;
  logic [7:0] key_last_reg;
  logic flash_reg;
  logic db_tick;
  logic [7:0] press;

  assign db_tick = (db_cnt_reg == 32'(DEBOUNCE_CYCLES - 1));
  // One action per press: a rising edge of the filtered level
  assign press = key_state_reg & ~key_last_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn || db_tick) begin
      db_cnt_reg <= 32'h0000_0000;
    end else begin
      db_cnt_reg <= db_cnt_reg + 32'h0000_0001;
    end
  end

  // A level counts only after two equal samples one debounce period apart
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      key_sample_reg <= 8'h00;
      key_state_reg <= 8'h00;
      key_last_reg <= 8'h00;
    end else begin
      key_last_reg <= key_state_reg;
      if (db_tick) begin
        key_sample_reg <= keys_raw;
        key_state_reg <= (keys_raw & key_sample_reg) | (key_state_reg & (keys_raw | key_sample_reg));
      end
    end
  end

  // Every flashing lamp and digit shares this one phase
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flash_cnt_reg <= 32'h0000_0000;
      flash_reg <= 1'b0;
    end else if (flash_cnt_reg == 32'(FLASH_CYCLES - 1)) begin
      flash_cnt_reg <= 32'h0000_0000;
      flash_reg <= ~flash_reg;
    end else begin
      flash_cnt_reg <= flash_cnt_reg + 32'h0000_0001;
    end
  end

  // ****************************************
  // Register file
  // ****************************************
  logic [1:0] cfg_src_reg;
  logic [1:0] cfg_mf_reg;
  logic cfg_tune_reg;
  panel_pkg::panel_state_t state_reg;
  logic [1:0] level_reg;
  logic fault_seen_reg;
  logic tune_go;
  logic keypad_src;
  logic cmd_ok;

  assign keypad_src = (cfg_src_reg == panel_pkg::SRC_KEYPAD);
  assign cmd_ok = (state_reg != panel_pkg::ST_INIT) && (state_reg != panel_pkg::ST_FAULT);
  assign tune_go = press[panel_pkg::KEY_RUN] && keypad_src && cfg_tune_reg && cmd_ok;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= panel_pkg::RESP_OKAY;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= panel_pkg::RESP_OKAY;
      cfg_src_reg <= panel_pkg::SRC_KEYPAD;
      cfg_mf_reg <= panel_pkg::MF_NONE;
      cfg_tune_reg <= 1'b0;
    end else begin
      awready <= awvalid && wvalid && !awready && !bvalid;
      wready <= awvalid && wvalid && !awready && !bvalid;
      if (tune_go) begin
        cfg_tune_reg <= 1'b0;
      end
      if (awready && awvalid) begin
        bvalid <= 1'b1;
        bresp <= panel_pkg::RESP_OKAY;
        if (awaddr[7:2] == panel_pkg::ADDR_CONFIG[7:2]) begin
          // A software write wins over the hardware clear of the arm bit
          if (wstrb[0]) begin
            cfg_src_reg <= wdata[panel_pkg::CFG_SRC_LSB +: 2];
            cfg_mf_reg <= wdata[panel_pkg::CFG_MF_LSB +: 2];
            cfg_tune_reg <= wdata[panel_pkg::CFG_TUNE_BIT];
          end
        end else if (awaddr[7:2] != panel_pkg::ADDR_STATUS[7:2]) begin
          bresp <= panel_pkg::RESP_SLVERR;
        end
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
      arready <= arvalid && !arready && !rvalid;
      if (arready && arvalid) begin
        rvalid <= 1'b1;
        rresp <= panel_pkg::RESP_OKAY;
        if (araddr[7:2] == panel_pkg::ADDR_CONFIG[7:2]) begin
          rdata <= {27'h0, cfg_tune_reg, cfg_mf_reg, cfg_src_reg};
        end else if (araddr[7:2] == panel_pkg::ADDR_STATUS[7:2]) begin
          rdata <= {26'h0, drive_status.fault, level_reg, state_reg};
        end else begin
          rdata <= 32'h0000_0000;
          rresp <= panel_pkg::RESP_SLVERR;
        end
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // Panel state sequencing
  // ****************************************
  logic reset_pend_reg;
  logic [7:0] reset_wait_reg;
  logic view_code_reg;
  logic fault_rise;
  logic stop_key_reset;
  panel_pkg::panel_state_t normal_state;

  assign fault_rise = drive_status.fault && !fault_seen_reg;
  assign stop_key_reset = press[panel_pkg::KEY_STOP] && (state_reg == panel_pkg::ST_FAULT)
    && !drive_status.running && !drive_status.stopping;
  assign normal_state = (drive_status.running || drive_status.stopping) ?
    panel_pkg::ST_RUN : panel_pkg::ST_STOP;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= panel_pkg::ST_INIT;
      init_cnt_reg <= 32'h0000_0000;
      fault_seen_reg <= 1'b0;
    end else begin
      fault_seen_reg <= drive_status.fault;
      case (state_reg)
        panel_pkg::ST_INIT: begin
          init_cnt_reg <= init_cnt_reg + 32'h0000_0001;
          if (init_cnt_reg == 32'(INIT_CYCLES - 1)) begin
            state_reg <= panel_pkg::ST_STOP;
          end
        end
        panel_pkg::ST_STOP, panel_pkg::ST_RUN: begin
          if (drive_status.fault) begin
            state_reg <= panel_pkg::ST_FAULT;
          end else if (press[panel_pkg::KEY_PROG] && !view_code_reg) begin
            state_reg <= panel_pkg::ST_PROG;
          end else begin
            state_reg <= normal_state;
          end
        end
        panel_pkg::ST_FAULT: begin
          if (press[panel_pkg::KEY_PROG]) begin
            state_reg <= panel_pkg::ST_PROG;
          end else if (reset_pend_reg && !drive_status.fault) begin
            state_reg <= normal_state;
          end
        end
        panel_pkg::ST_PROG: begin
          if (fault_rise) begin
            state_reg <= panel_pkg::ST_FAULT;
          end else if (press[panel_pkg::KEY_PROG] && level_reg == 2'd1) begin
            state_reg <= drive_status.fault ? panel_pkg::ST_FAULT : normal_state;
          end
        end
        default: state_reg <= panel_pkg::ST_INIT;
      endcase
    end
  end

  // A reset request stays open for a short window; a fault still present after it stays shown
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reset_pend_reg <= 1'b0;
      reset_wait_reg <= 8'h00;
    end else if (stop_key_reset) begin
      reset_pend_reg <= 1'b1;
      reset_wait_reg <= 8'(panel_pkg::RESET_WAIT_CYCLES);
    end else if (reset_wait_reg != 8'h00) begin
      reset_wait_reg <= reset_wait_reg - 8'h01;
    end else begin
      reset_pend_reg <= 1'b0;
    end
  end

  // ****************************************
  // Monitor view and three-level menu
  // ****************************************
  logic [4:0] view_idx_reg;
  logic [3:0] group_reg;
  logic [4:0] code_reg;
  logic [15:0] value_reg;
  logic [1:0] digit_reg;
  logic in_prog;
  logic in_view;

  assign in_prog = (state_reg == panel_pkg::ST_PROG);
  assign in_view = (state_reg == panel_pkg::ST_STOP) || (state_reg == panel_pkg::ST_RUN);

  always_ff @(posedge aclk) begin
    if (!aresetn || !in_view) begin
      view_idx_reg <= 5'h00;
      view_code_reg <= 1'b0;
    end else if (press[panel_pkg::KEY_SHIFT]) begin
      view_idx_reg <= next_idx(view_idx_reg, (state_reg == panel_pkg::ST_RUN) ?
        panel_pkg::RUN_CODE_MAX : panel_pkg::STOP_CODE_MAX);
      view_code_reg <= 1'b1;
    end else if (press[panel_pkg::KEY_CONFIRM] || press[panel_pkg::KEY_PROG]) begin
      view_code_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level_reg <= 2'd0;
      group_reg <= 4'h0;
      code_reg <= 5'h00;
      value_reg <= 16'h0000;
      digit_reg <= 2'd0;
      param_write <= 1'b0;
      param_wdata <= 16'h0000;
    end else begin
      param_write <= 1'b0;
      if (!in_prog) begin
        level_reg <= 2'd0;
        if (state_reg == panel_pkg::ST_FAULT) begin
          group_reg <= panel_pkg::FAULT_LOG_GROUP;
        end
      end else if (level_reg == 2'd0) begin
        level_reg <= 2'd1;
      end else if (press[panel_pkg::KEY_PROG]) begin
        level_reg <= level_reg - 2'd1;
      end else if (press[panel_pkg::KEY_CONFIRM]) begin
        case (level_reg)
          2'd1: begin
            level_reg <= 2'd2;
            code_reg <= 5'h00;
          end
          2'd2: begin
            level_reg <= 2'd3;
            value_reg <= param_rdata;
            digit_reg <= 2'd0;
          end
          default: begin
            param_write <= 1'b1;
            param_wdata <= value_reg;
            level_reg <= 2'd2;
            code_reg <= next_idx(code_reg, panel_pkg::PARAM_CODE_MAX);
          end
        endcase
      end else if (press[panel_pkg::KEY_UP]) begin
        case (level_reg)
          2'd1: group_reg <= group_reg + 4'h1;
          2'd2: code_reg <= next_idx(code_reg, panel_pkg::PARAM_CODE_MAX);
          default: value_reg <= value_reg + digit_step(digit_reg);
        endcase
      end else if (press[panel_pkg::KEY_DOWN]) begin
        case (level_reg)
          2'd1: group_reg <= group_reg - 4'h1;
          2'd2: code_reg <= (code_reg == 5'h00) ? panel_pkg::PARAM_CODE_MAX :
            code_reg - 5'h01;
          default: value_reg <= value_reg - digit_step(digit_reg);
        endcase
      end else if (press[panel_pkg::KEY_SHIFT] && level_reg == 2'd3) begin
        digit_reg <= digit_reg + 2'd1;
      end
    end
  end

  assign param_addr = {group_reg, code_reg};
  assign monitor_sel = {(state_reg == panel_pkg::ST_RUN), view_idx_reg};

  // ****************************************
  // Drive commands
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drive_cmd <= '0;
    end else begin
      drive_cmd.tune <= tune_go;
      drive_cmd.run <= press[panel_pkg::KEY_RUN] && keypad_src && cmd_ok && !cfg_tune_reg;
      drive_cmd.fault_reset <= stop_key_reset;
      drive_cmd.stop <= press[panel_pkg::KEY_STOP] && keypad_src && !stop_key_reset;
      drive_cmd.jog_fwd <= key_state_reg[panel_pkg::KEY_MF] && cmd_ok
        && cfg_mf_reg == panel_pkg::MF_JOG_FWD;
      drive_cmd.jog_rev <= key_state_reg[panel_pkg::KEY_MF] && cmd_ok
        && cfg_mf_reg == panel_pkg::MF_JOG_REV;
    end
  end

  // ****************************************
  // Lamps and display
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn || state_reg == panel_pkg::ST_INIT) begin
      lamps <= '1;
    end else begin
      lamps.cmd_source <= (cfg_src_reg == panel_pkg::SRC_TERMINAL) ||
        ((cfg_src_reg == panel_pkg::SRC_SERIAL) && flash_reg);
      lamps.run <= drive_status.running || (drive_status.stopping && flash_reg);
      lamps.direction <= drive_status.forward;
      lamps.fault <= drive_status.fault;
      lamps.unit <= (in_view && !view_code_reg) ? unit_lamps(monitor_kind) : 3'b000;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || state_reg == panel_pkg::ST_INIT) begin
      display.glyph <= {4{panel_pkg::GLYPH_EIGHT}};
      display.point <= 4'hf;
    end else begin
      display.point <= 4'h0;
      case (state_reg)
        panel_pkg::ST_FAULT: begin
          display.glyph <= flash_reg ? {4{panel_pkg::GLYPH_BLANK}} :
            {panel_pkg::GLYPH_E, panel_pkg::GLYPH_DASH, 1'b0, drive_status.fault_code[7:4],
             1'b0, drive_status.fault_code[3:0]};
        end
        panel_pkg::ST_PROG: begin
          case (level_reg)
            2'd3: begin
              display.glyph <= hex4(value_reg);
              if (flash_reg) begin
                display.glyph[digit_reg] <= panel_pkg::GLYPH_BLANK;
              end
            end
            2'd2: begin
              display.glyph <= {panel_pkg::GLYPH_P, 1'b0, group_reg, dec2(code_reg)};
              display.point <= 4'h4;
            end
            default: begin
              display.glyph <= {panel_pkg::GLYPH_P, 1'b0, group_reg,
                panel_pkg::GLYPH_BLANK, panel_pkg::GLYPH_BLANK};
              display.point <= 4'h4;
            end
          endcase
        end
        default: begin
          if (view_code_reg) begin
            display.glyph <= {(state_reg == panel_pkg::ST_RUN) ? panel_pkg::GLYPH_R :
              panel_pkg::GLYPH_N, panel_pkg::GLYPH_DASH, dec2(view_idx_reg)};
          end else if (state_reg == panel_pkg::ST_STOP && flash_reg) begin
            display.glyph <= {4{panel_pkg::GLYPH_BLANK}};
          end else begin
            display.glyph <= hex4(monitor_value);
          end
        end
      endcase
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_src_lamp_keypad: assert property ((state_reg != panel_pkg::ST_INIT) && keypad_src
    |=> !lamps.cmd_source) else $error("source lamp lit on keypad");
  a_run_lamp_on: assert property ((state_reg != panel_pkg::ST_INIT) && drive_status.running
    |=> lamps.run) else $error("run lamp dark while running");
  a_dir_lamp: assert property ((state_reg != panel_pkg::ST_INIT)
    |=> lamps.direction == $past(drive_status.forward)) else $error("direction lamp wrong");
  a_fault_lamp: assert property ((state_reg != panel_pkg::ST_INIT)
    |=> lamps.fault == $past(drive_status.fault)) else $error("fault lamp wrong");
  a_init_all_on: assert property ((state_reg == panel_pkg::ST_INIT) ##1
    (state_reg == panel_pkg::ST_INIT) |-> display.point == 4'hf && lamps.run)
    else $error("init pattern missing");
  a_init_end: assert property ((state_reg == panel_pkg::ST_INIT) &&
    init_cnt_reg == 32'(INIT_CYCLES - 1) |=> state_reg == panel_pkg::ST_STOP)
    else $error("init did not end");
  a_run_gated: assert property (drive_cmd.run |-> $past(cfg_src_reg) == panel_pkg::SRC_KEYPAD)
    else $error("run issued from wrong source");
  a_save_advance: assert property (in_prog && level_reg == 2'd3 &&
    press[panel_pkg::KEY_CONFIRM] && !press[panel_pkg::KEY_PROG] |=> param_write &&
    level_reg == 2'd2 && code_reg == next_idx($past(code_reg), panel_pkg::PARAM_CODE_MAX))
    else $error("save did not advance");
  a_discard_edit: assert property (in_prog && level_reg == 2'd3 &&
    press[panel_pkg::KEY_PROG] |=> !param_write && level_reg == 2'd2 && $stable(code_reg))
    else $error("discard wrote or moved");
  a_fault_enter: assert property (in_view && drive_status.fault
    |=> state_reg == panel_pkg::ST_FAULT) else $error("fault not entered");
  a_one_action: assert property (press[panel_pkg::KEY_RUN] |=> (!press[panel_pkg::KEY_RUN])[*2])
    else $error("double key action");

  c_init_done: cover property ((state_reg == panel_pkg::ST_INIT) ##1
    (state_reg == panel_pkg::ST_STOP));
  c_param_saved: cover property (param_write);
  c_fault_reset: cover property (drive_cmd.fault_reset ##[1:300]
    (state_reg != panel_pkg::ST_FAULT));
  c_run_start: cover property (drive_cmd.run);

endmodule
`default_nettype wire

// *** shared/panel_pkg.sv ***
// Purpose: Constants and types for the keypad panel and menu controller
// Assumes: 20 MHz aclk, registers on AXI4-Lite
// Notes: Long counts become top-level parameters
package panel_pkg;
  localparam int CLK_HZ = 20_000_000;
  localparam int INIT_TIME_MS = 5000;
  localparam int INIT_CYCLES = INIT_TIME_MS * (CLK_HZ / 1000);
  localparam int DEBOUNCE_MS = 10;
  localparam int DEBOUNCE_CYCLES = DEBOUNCE_MS * (CLK_HZ / 1000);
  localparam int FLASH_MS = 250;
  localparam int FLASH_CYCLES = FLASH_MS * (CLK_HZ / 1000);
  localparam int RESET_WAIT_US = 10;
  localparam int RESET_WAIT_CYCLES = RESET_WAIT_US * (CLK_HZ / 1_000_000);
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int CFG_SRC_LSB = 0;
  localparam int CFG_MF_LSB = 2;
  localparam int CFG_TUNE_BIT = 4;
  localparam logic [1:0] SRC_KEYPAD = 2'h0;
  localparam logic [1:0] SRC_TERMINAL = 2'h1;
  localparam logic [1:0] SRC_SERIAL = 2'h2;
  localparam logic [1:0] MF_NONE = 2'h0;
  localparam logic [1:0] MF_JOG_FWD = 2'h1;
  localparam logic [1:0] MF_JOG_REV = 2'h2;
  localparam int KEY_PROG = 0;
  localparam int KEY_CONFIRM = 1;
  localparam int KEY_UP = 2;
  localparam int KEY_DOWN = 3;
  localparam int KEY_SHIFT = 4;
  localparam int KEY_RUN = 5;
  localparam int KEY_STOP = 6;
  localparam int KEY_MF = 7;
  localparam logic [4:0] STOP_CODE_MAX = 5'h08;
  localparam logic [4:0] RUN_CODE_MAX = 5'h0e;
  localparam logic [4:0] PARAM_CODE_MAX = 5'h1f;
  localparam logic [3:0] FAULT_LOG_GROUP = 4'he;
  localparam logic [4:0] GLYPH_DASH = 5'h10;
  localparam logic [4:0] GLYPH_N = 5'h11;
  localparam logic [4:0] GLYPH_R = 5'h12;
  localparam logic [4:0] GLYPH_BLANK = 5'h13;
  localparam logic [4:0] GLYPH_P = 5'h14;
  localparam logic [4:0] GLYPH_E = 5'h0e;
  localparam logic [4:0] GLYPH_EIGHT = 5'h08;
  localparam logic [2:0] UNIT_HZ = 3'b001;
  localparam logic [2:0] UNIT_A = 3'b010;
  localparam logic [2:0] UNIT_V = 3'b100;
  localparam logic [2:0] UNIT_RPM = 3'b011;
  localparam logic [2:0] UNIT_TIME = 3'b110;
  localparam logic [2:0] UNIT_PCT = 3'b101;
  typedef enum logic [2:0] {ST_INIT, ST_STOP, ST_RUN, ST_FAULT, ST_PROG} panel_state_t;
  typedef enum logic [2:0] {Q_FREQ, Q_CURR, Q_VOLT, Q_SPEED, Q_TIME, Q_PCT} quantity_t;
  typedef struct packed {logic cmd_source; logic run; logic direction; logic fault;
    logic [2:0] unit;} lamps_t;
  typedef struct packed {logic [3:0][4:0] glyph; logic [3:0] point;} display_t;
  typedef struct packed {logic run; logic stop; logic tune; logic fault_reset;
    logic jog_fwd; logic jog_rev;} drive_cmd_t;
  typedef struct packed {logic running; logic stopping; logic forward; logic fault;
    logic [7:0] fault_code;} drive_status_t;
endpackage

// *** verification/drive_core_model.sv ***
// Purpose: Drive core model behind the panel
// Assumes: Fault level set by the bench
// Notes: Every parameter word starts at 16'h1234
`timescale 1ns/1ps
`default_nettype none
module drive_core_model (
  input wire logic aclk,
  input wire logic [8:0] param_addr,
  input wire logic [15:0] param_wdata,
  input wire logic param_write,
  input wire panel_pkg::drive_cmd_t drive_cmd,
  input wire logic fault_in,
  output panel_pkg::drive_status_t drive_status,
  output logic [15:0] param_rdata
);
  logic [15:0] mem [512] = '{default: 16'h1234};
  logic run_reg = 1'h0;
  logic fwd_reg = 1'h1;
  always @(posedge aclk) begin
    if (param_write) mem[param_addr] <= param_wdata;
    if (drive_cmd.run | drive_cmd.stop) run_reg <= drive_cmd.run;
    if (drive_cmd.jog_fwd | drive_cmd.jog_rev) fwd_reg <= drive_cmd.jog_fwd;
  end
  // Direction follows the last jog, so both lamp levels show
  assign drive_status = {run_reg, 1'h0, fwd_reg, fault_in, 8'h21};
  assign param_rdata = mem[param_addr];
endmodule
`default_nettype wire

// *** verification/keypad_panel_menu_controller_bench.sv ***
// Purpose: Self-checking bench for the panel controller
// Assumes: Short counts set through parameters
// Notes: Keys held well past the debounce time
`timescale 1ns/1ps
`default_nettype none
module keypad_panel_menu_controller_bench;
  logic aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, arvalid = 1'h0;
  logic bready = 1'h0, rready = 1'h0, fault_in = 1'h0, awready, bvalid, arready, rvalid;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0, keys_raw = 8'h0;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [15:0] param_wdata, param_rdata, last_w;
  logic [1:0] rresp, rs;
  logic [8:0] param_addr;
  logic param_write;
  panel_pkg::drive_status_t drive_status;
  panel_pkg::display_t display;
  panel_pkg::lamps_t lamps;
  panel_pkg::drive_cmd_t drive_cmd;
  panel_pkg::quantity_t kind = panel_pkg::Q_FREQ;
  int fails = 0, check_count = 0, pulses [4] = '{default: 0};
  always #25 aclk = ~aclk;
  always @(posedge aclk) begin
    foreach (pulses[i]) pulses[i] += int'(drive_cmd[5-i] === 1'h1);
    if (param_write === 1'h1) last_w <= param_wdata;
  end
  keypad_panel_menu_controller #(.INIT_CYCLES(20), .DEBOUNCE_CYCLES(4), .FLASH_CYCLES(8)) DUT (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hf), .wvalid, .wready(),
    .bresp(), .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .keys_raw, .drive_status, .monitor_kind(kind), .monitor_value(16'h0),
    .param_rdata, .display, .lamps, .drive_cmd, .monitor_sel(), .param_addr, .param_wdata,
    .param_write);
  drive_core_model core (.aclk, .param_addr, .param_wdata, .param_write, .drive_cmd,
    .fault_in, .drive_status, .param_rdata);
  task automatic report_and_stop();
    if (fails == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) fails++;
    if (g !== e) $display("Error %s expected %h seen %h", n, e, g);
  endtask
  task automatic wait_hi(ref logic s);
    int n = 0;
    do @(posedge aclk); while (s !== 1'h1 && ++n < 200);
    if (s !== 1'h1) fails++;
    if (s !== 1'h1) report_and_stop();
  endtask
  // Address and data go out together; only one channel pair per call
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    {awaddr, araddr, wdata} <= {a, a, d};
    {awvalid, wvalid, bready, arvalid, rready} <= {w, w, w, !w, !w};
    if (w) wait_hi(awready);
    else wait_hi(arready);
    {awvalid, wvalid, arvalid} <= 3'h0;
    if (w) wait_hi(bvalid);
    else wait_hi(rvalid);
    {rd, rs} = {rdata, rresp};
    {bready, rready} <= 2'h0;
  endtask
  task automatic press(input int k);
    keys_raw[k] <= 1'h1;
    repeat (20) @(posedge aclk);
    keys_raw[k] <= 1'h0;
    repeat (20) @(posedge aclk);
  endtask
  task automatic state_is(input string n, input logic [31:0] e);
    bus(1'h0, 8'h04, 32'h0);
    check(n, rd & 32'h7, e);
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic t_init();
    kind <= panel_pkg::Q_SPEED;
    check("display", 32'(display), 32'h42108f);
    check("lamps", 32'(lamps), 32'h7f);
    repeat (30) @(posedge aclk);
    state_is("stopped", 32'h1);
    press(panel_pkg::KEY_SHIFT);
    check("stop_code", 32'(display), 32'h8c0010);
    press(panel_pkg::KEY_CONFIRM);
    check("unit", 32'(lamps.unit), 32'h3);
  endtask
  task automatic t_source();
    int on;
    for (int s = 2; s >= 0; s--) begin
      bus(1'h1, 8'h00, 32'(s));
      on = 0;
      repeat (4) @(posedge aclk);
      repeat (48) @(posedge aclk) on += int'(lamps.cmd_source === 1'h1);
      check("source_lamp", 32'(on), s == 2 ? 32'h18 : 32'(s * 48));
    end
    bus(1'h0, 8'h08, 32'h0);
    check("unmapped", 32'(rs), 32'h2);
  endtask
  task automatic t_menu();
    press(panel_pkg::KEY_PROG);
    state_is("programming", 32'h4);
    press(panel_pkg::KEY_CONFIRM);
    press(panel_pkg::KEY_CONFIRM);
    press(panel_pkg::KEY_UP);
    press(panel_pkg::KEY_CONFIRM);
    check("saved", 32'(last_w), 32'h1235);
    check("next_code", 32'(param_addr[4:0]), 32'h1);
    press(panel_pkg::KEY_CONFIRM);
    press(panel_pkg::KEY_SHIFT);
    press(panel_pkg::KEY_UP);
    press(panel_pkg::KEY_PROG);
    check("discard", 32'(last_w), 32'h1235);
    check("same_code", 32'(param_addr[4:0]), 32'h1);
    press(panel_pkg::KEY_PROG);
    press(panel_pkg::KEY_PROG);
    state_is("left_menu", 32'h1);
  endtask
  task automatic t_run();
    bus(1'h1, 8'h00, 32'h1);
    press(panel_pkg::KEY_RUN);
    check("gated_run", 32'(pulses[0]), 32'h0);
    bus(1'h1, 8'h00, 32'h0);
    press(panel_pkg::KEY_RUN);
    check("run_cmd", 32'(pulses[0]), 32'h1);
    check("run_dir", 32'(lamps[5:4]), 32'h3);
    state_is("running", 32'h2);
    press(panel_pkg::KEY_STOP);
    check("stop_cmd", 32'(pulses[1]), 32'h1);
    bus(1'h1, 8'h00, 32'h8);
    keys_raw[panel_pkg::KEY_MF] <= 1'h1;
    repeat (20) @(posedge aclk);
    check("jog", 32'(drive_cmd[1:0]), 32'h1);
    check("rev_lamp", 32'(lamps.direction), 32'h0);
    keys_raw[panel_pkg::KEY_MF] <= 1'h0;
    repeat (20) @(posedge aclk);
  endtask
  task automatic t_fault();
    fault_in <= 1'h1;
    repeat (10) @(posedge aclk);
    check("fault_lamp", 32'(lamps.fault), 32'h1);
    press(panel_pkg::KEY_STOP);
    repeat (220) @(posedge aclk);
    state_is("held", 32'h3);
    fault_in <= 1'h0;
    press(panel_pkg::KEY_STOP);
    repeat (220) @(posedge aclk);
    check("clears", 32'(pulses[3]), 32'h2);
    state_is("recovered", 32'h1);
  endtask
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    t_init();
    t_source();
    t_menu();
    t_run();
    t_fault();
    report_and_stop();
  end
endmodule
`default_nettype wire
